// File: rtl/flash_regs_pkg.sv
`default_nettype none
package flash_regs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS_TWO = 8'h00;
  localparam logic [7:0] OFS_BANK_ADDRESS_SELECT = 8'h04;
  localparam logic [7:0] OFS_SECTOR_GUARD_CONFIG = 8'h08;
  localparam logic [7:0] OFS_KEY_LOW = 8'h0c;
  localparam logic [7:0] OFS_KEY_HIGH = 8'h10;
  localparam logic [7:0] OFS_LINK_ADDRESS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ERASE_SUSPENDED_BIT = 1;
  localparam int PROGRAM_SUSPENDED_BIT = 0;
  localparam int WIDE_ADDRESS_ENABLE_BIT = 7;
  localparam int BANK_BIT_HIGH_POS = 1;
  localparam int BANK_BIT_LOW_POS = 0;
  localparam int KEY_MODE_LOCK_BIT = 2;
  localparam int PERSISTENT_MODE_LOCK_BIT = 1;

  // Writable bits of the bank register: wide enable and both bank bits
  localparam logic [7:0] BANK_WRITE_MASK = 8'h83;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [15:0] GUARD_RESET = 16'hfe7f;
  localparam logic [63:0] KEY_RESET = 64'hffff_ffff_ffff_ffff;
  localparam logic [31:0] KEY_HIDDEN_VALUE = 32'hffff_ffff;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Serial framing counts
  // ----------------------------------------------------------------
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] NARROW_ADDRESS_BITS = 6'h18;
  localparam logic [5:0] WIDE_ADDRESS_BITS = 6'h20;

endpackage
`default_nettype wire

// File: rtl/link_pins_if.sv
`default_nettype none
interface link_pins_if;
  logic cs_n;
  logic si;
  logic sck_rise;

  modport source (output cs_n, output si, output sck_rise);
  modport sink (input cs_n, input si, input sck_rise);
endinterface
`default_nettype wire

// File: rtl/link_pin_sync.sv
`default_nettype none
module link_pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw link pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  // Synchronised view
  link_pins_if.source pins
);

  // Bit order in the vectors: {si, sck, cs_n}; select idles high
  localparam logic [2:0] IDLE_LEVELS = 3'b001;

  logic [2:0] meta;
  logic [2:0] stable;
  logic sck_prev;
  logic [2:0] next_meta;
  logic [2:0] next_stable;
  logic next_sck_prev;

  // Two flops per pin; only the second stage feeds the edge finder
  always_comb begin
    next_meta = {si_i, sck_i, cs_n_i};
    next_stable = meta;
    next_sck_prev = stable[1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= IDLE_LEVELS;
      stable <= IDLE_LEVELS;
      sck_prev <= 1'b0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      sck_prev <= next_sck_prev;
    end
  end

  // Rising serial clock seen in the cycle it settles
  assign pins.cs_n = stable[0];
  assign pins.si = stable[2];
  assign pins.sck_rise = stable[1] & ~sck_prev;

endmodule
`default_nettype wire

// File: rtl/flash_status_bank_protect_regs.sv
// Contract
// - Erase-suspended flag is read-only, set while erase suspended, resets to zero.
// - Program-suspended flag is read-only, set while program suspended, resets to zero.
// - Bank bit 7 enables wide addressing: 32-bit addresses; resets to zero.
// - Narrow mode takes 24-bit addresses; bank bits join above them.
// - Bank bit 0 is address bit 24; bit 1 reserved; both reset zero.
// - Guard config bit 2 is one-time lock; zero selects key mode; ships one.
// - Guard config bit 1 is one-time lock; zero selects persistent mode; ships one.
// - Hidden 64-bit key held in one-time storage, bits 63 to 0.
// - Once key mode lock is zero, the key is never read back.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`default_nettype none
module flash_status_bank_protect_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [flash_regs_pkg::ADDR_W-1:0] adr_i,
  input wire logic [flash_regs_pkg::DATA_W-1:0] dat_i,
  input wire logic [flash_regs_pkg::SEL_W-1:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [flash_regs_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  // Suspend and resume events from the array sequencer
  input wire logic erase_suspend_i,
  input wire logic erase_resume_i,
  input wire logic program_suspend_i,
  input wire logic program_resume_i,
  // Serial link pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  // Block state
  output logic erase_suspended_o,
  output logic program_suspended_o,
  output logic wide_address_enable_o,
  output logic key_mode_active_o,
  output logic persistent_mode_active_o,
  output logic [31:0] full_address_o,
  output logic address_valid_o
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Expand byte selects into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  // One-time storage only ever clears bits: unselected lanes keep all
  function automatic logic [31:0] otp_program(input logic [31:0] old, input logic [31:0] wr,
                                              input logic [3:0] sel);
    return old & (wr | ~lane_mask(sel));
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic ack;
  logic [31:0] rdata;
  logic erase_suspended;
  logic program_suspended;
  logic [7:0] bank_select;
  logic [15:0] guard_config;
  logic [63:0] secret_key_value;
  logic [31:0] full_address;
  logic address_valid;

  logic next_ack;
  logic [31:0] next_rdata;
  logic next_erase_suspended;
  logic next_program_suspended;
  logic [7:0] next_bank_select;
  logic [15:0] next_guard_config;
  logic [63:0] next_secret_key_value;

  logic req;
  logic wr_take;
  logic [31:0] wmask;
  logic [7:0] status_two;

  link_pins_if link_pins ();

  link_pin_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sck_i (sck_i),
    .cs_n_i (cs_n_i),
    .si_i (si_i),
    .pins (link_pins.source)
  );

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------

  // A write lands on the edge where the master sees ack, never earlier
  assign req = cyc_i & stb_i;
  assign wr_take = req & we_i & ack;
  assign wmask = lane_mask(sel_i);

  // Status two: six reserved bits read zero
  always_comb begin
    status_two = flash_regs_pkg::STATUS_TWO_RESET;
    status_two[flash_regs_pkg::ERASE_SUSPENDED_BIT] = erase_suspended;
    status_two[flash_regs_pkg::PROGRAM_SUSPENDED_BIT] = program_suspended;
  end

  // Read mux; unmapped offsets answer with zero data
  function automatic logic [31:0] read_word(input logic [7:0] adr);
    logic [31:0] w;
    w = flash_regs_pkg::UNMAPPED_VALUE;
    case (adr)
      flash_regs_pkg::OFS_STATUS_TWO: begin
        w = {24'h00_0000, status_two};
      end
      flash_regs_pkg::OFS_BANK_ADDRESS_SELECT: begin
        w = {24'h00_0000, bank_select};
      end
      flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG: begin
        w = {16'h0000, guard_config};
      end
      flash_regs_pkg::OFS_KEY_LOW: begin
        w = guard_config[flash_regs_pkg::KEY_MODE_LOCK_BIT] ? secret_key_value[31:0]
                                                             : flash_regs_pkg::KEY_HIDDEN_VALUE;
      end
      flash_regs_pkg::OFS_KEY_HIGH: begin
        w = guard_config[flash_regs_pkg::KEY_MODE_LOCK_BIT] ? secret_key_value[63:32]
                                                             : flash_regs_pkg::KEY_HIDDEN_VALUE;
      end
      flash_regs_pkg::OFS_LINK_ADDRESS: begin
        w = full_address;
      end
      default: begin
        w = flash_regs_pkg::UNMAPPED_VALUE;
      end
    endcase
    return w;
  endfunction

  // Ack one cycle after the request, dropped the cycle after
  always_comb begin
    next_ack = req & ~ack;
    next_rdata = (req & ~ack & ~we_i) ? read_word(adr_i) : 32'h0000_0000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  // Suspend flags follow the sequencer only; a suspend beats a resume
  always_comb begin
    next_erase_suspended = erase_suspend_i | (erase_suspended & ~erase_resume_i);
    next_program_suspended = program_suspend_i | (program_suspended & ~program_resume_i);
  end

  // Bank register: bits 6..2 stay zero whatever is written
  always_comb begin
    next_bank_select = bank_select;
    if (wr_take && adr_i == flash_regs_pkg::OFS_BANK_ADDRESS_SELECT) begin
      next_bank_select = (bank_select & ~(flash_regs_pkg::BANK_WRITE_MASK & wmask[7:0]))
                       | (dat_i[7:0] & flash_regs_pkg::BANK_WRITE_MASK & wmask[7:0]);
    end
  end

  // One-time bits: a write can only clear, never set back
  always_comb begin
    next_guard_config = guard_config;
    next_secret_key_value = secret_key_value;
    if (wr_take) begin
      case (adr_i)
        flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG: begin
          next_guard_config = guard_config & (dat_i[15:0] | ~wmask[15:0]);
        end
        flash_regs_pkg::OFS_KEY_LOW: begin
          next_secret_key_value[31:0] = otp_program(secret_key_value[31:0], dat_i, sel_i);
        end
        flash_regs_pkg::OFS_KEY_HIGH: begin
          next_secret_key_value[63:32] = otp_program(secret_key_value[63:32], dat_i, sel_i);
        end
        default: begin
          next_guard_config = guard_config;
        end
      endcase
    end
  end

  // Reset stands in for a blank part at power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_suspended <= 1'b0;
      program_suspended <= 1'b0;
      bank_select <= flash_regs_pkg::BANK_RESET;
      guard_config <= flash_regs_pkg::GUARD_RESET;
      secret_key_value <= flash_regs_pkg::KEY_RESET;
    end else begin
      erase_suspended <= next_erase_suspended;
      program_suspended <= next_program_suspended;
      bank_select <= next_bank_select;
      guard_config <= next_guard_config;
      secret_key_value <= next_secret_key_value;
    end
  end

  // ----------------------------------------------------------------
  // Serial address capture
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LINK_IDLE, LINK_OPCODE, LINK_ADDRESS, LINK_WAIT_END} link_state_e;

  link_state_e link_state;
  logic [5:0] bit_count;
  logic [31:0] shift;
  logic wide_frame;

  link_state_e next_link_state;
  logic [5:0] next_bit_count;
  logic [31:0] next_shift;
  logic next_wide_frame;
  logic [31:0] next_full_address;
  logic next_address_valid;
  logic [31:0] shifted;
  logic [5:0] address_bits;

  // Width is fixed at frame start so a mid-frame bank write cannot split it
  assign address_bits = wide_frame ? flash_regs_pkg::WIDE_ADDRESS_BITS
                                   : flash_regs_pkg::NARROW_ADDRESS_BITS;
  assign shifted = {shift[30:0], link_pins.si};

  always_comb begin
    next_link_state = link_state;
    next_bit_count = bit_count;
    next_shift = shift;
    next_wide_frame = wide_frame;
    next_full_address = full_address;
    next_address_valid = 1'b0;
    case (link_state)
      LINK_IDLE: begin
        if (!link_pins.cs_n) begin
          next_link_state = LINK_OPCODE;
          next_bit_count = 6'h00;
          next_shift = 32'h0000_0000;
          next_wide_frame = bank_select[flash_regs_pkg::WIDE_ADDRESS_ENABLE_BIT];
        end
      end
      LINK_OPCODE: begin
        if (link_pins.sck_rise) begin
          next_bit_count = bit_count + 6'h01;
          if (bit_count == flash_regs_pkg::OPCODE_BITS - 6'h01) begin
            next_link_state = LINK_ADDRESS;
            next_bit_count = 6'h00;
          end
        end
      end
      LINK_ADDRESS: begin
        if (link_pins.sck_rise) begin
          next_shift = shifted;
          next_bit_count = bit_count + 6'h01;
          if (bit_count == address_bits - 6'h01) begin
            next_link_state = LINK_WAIT_END;
            next_address_valid = 1'b1;
            if (wide_frame) begin
              next_full_address = shifted;
            end else begin
              next_full_address = {7'h00, bank_select[flash_regs_pkg::BANK_BIT_LOW_POS],
                                   shifted[23:0]};
            end
          end
        end
      end
      LINK_WAIT_END: begin
        next_link_state = LINK_WAIT_END;
      end
      default: begin
        next_link_state = LINK_IDLE;
      end
    endcase
    // A deselect aborts any frame; a short frame yields no address
    if (link_pins.cs_n) begin
      next_link_state = LINK_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_state <= LINK_IDLE;
      bit_count <= 6'h00;
      shift <= 32'h0000_0000;
      wide_frame <= 1'b0;
      full_address <= 32'h0000_0000;
      address_valid <= 1'b0;
    end else begin
      link_state <= next_link_state;
      bit_count <= next_bit_count;
      shift <= next_shift;
      wide_frame <= next_wide_frame;
      full_address <= next_full_address;
      address_valid <= next_address_valid;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops; the two mode flags are inverted lock bits
  // ----------------------------------------------------------------
  assign ack_o = ack;
  assign dat_o = rdata;
  assign erase_suspended_o = erase_suspended;
  assign program_suspended_o = program_suspended;
  assign wide_address_enable_o = bank_select[flash_regs_pkg::WIDE_ADDRESS_ENABLE_BIT];
  assign key_mode_active_o = ~guard_config[flash_regs_pkg::KEY_MODE_LOCK_BIT];
  assign persistent_mode_active_o = ~guard_config[flash_regs_pkg::PERSISTENT_MODE_LOCK_BIT];
  assign full_address_o = full_address;
  assign address_valid_o = address_valid;

endmodule
`default_nettype wire

// File: tb/flash_status_bank_protect_regs_properties.sv
`default_nettype none
module flash_status_bank_protect_regs_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [flash_regs_pkg::ADDR_W-1:0] adr_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [flash_regs_pkg::DATA_W-1:0] dat_o,
  input wire logic ack_o,
  // Suspend events
  input wire logic erase_suspend_i,
  input wire logic erase_resume_i,
  input wire logic program_suspend_i,
  input wire logic program_resume_i,
  // Block state
  input wire logic erase_suspended_o,
  input wire logic program_suspended_o,
  input wire logic key_mode_active_o,
  input wire logic persistent_mode_active_o,
  input wire logic address_valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Key read answered while the key mode lock is programmed
  sequence s_key_read_locked;
    ack_o && !we_i && key_mode_active_o && (adr_i == flash_regs_pkg::OFS_KEY_LOW ||
      adr_i == flash_regs_pkg::OFS_KEY_HIGH);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ack_after_req; s_req |=> ack_o ##1 !ack_o; endproperty
  property p_dat_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
  property p_key_hidden; s_key_read_locked |-> dat_o == flash_regs_pkg::KEY_HIDDEN_VALUE; endproperty
  property p_key_lock_sticky; key_mode_active_o |=> key_mode_active_o; endproperty
  property p_persist_lock_sticky; persistent_mode_active_o |=> persistent_mode_active_o; endproperty
  property p_es_set; erase_suspend_i |=> erase_suspended_o; endproperty
  property p_es_clear; erase_resume_i && !erase_suspend_i |=> !erase_suspended_o; endproperty
  property p_es_hold; !erase_suspend_i && !erase_resume_i |=> $stable(erase_suspended_o); endproperty
  property p_ps_set; program_suspend_i |=> program_suspended_o; endproperty
  property p_ps_clear; program_resume_i && !program_suspend_i |=> !program_suspended_o; endproperty
  property p_ps_hold; !program_suspend_i && !program_resume_i |=> $stable(program_suspended_o); endproperty
  property p_valid_pulse; address_valid_o |=> !address_valid_o; endproperty
  // Only the watched outputs matter; the bus comes back one cycle after a request
  a_ack_after_req: assert property (p_ack_after_req) else $error("ack not a single pulse after request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
  a_key_hidden: assert property (p_key_hidden) else $error("key visible after lock");
  a_key_lock_sticky: assert property (p_key_lock_sticky) else $error("key lock returned");
  a_persist_lock_sticky: assert property (p_persist_lock_sticky) else $error("persist lock returned");
  a_es_set: assert property (p_es_set) else $error("erase flag not set");
  a_es_clear: assert property (p_es_clear) else $error("erase flag not cleared");
  a_es_hold: assert property (p_es_hold) else $error("erase flag changed alone");
  a_ps_set: assert property (p_ps_set) else $error("program flag not set");
  a_ps_clear: assert property (p_ps_clear) else $error("program flag not cleared");
  a_ps_hold: assert property (p_ps_hold) else $error("program flag changed alone");
  a_valid_pulse: assert property (p_valid_pulse) else $error("address valid too long");
endmodule

bind flash_status_bank_protect_regs flash_status_bank_protect_regs_properties flash_status_bank_protect_regs_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
  .ack_o(ack_o), .erase_suspend_i(erase_suspend_i), .erase_resume_i(erase_resume_i),
  .program_suspend_i(program_suspend_i), .program_resume_i(program_resume_i),
  .erase_suspended_o(erase_suspended_o), .program_suspended_o(program_suspended_o),
  .key_mode_active_o(key_mode_active_o), .persistent_mode_active_o(persistent_mode_active_o),
  .address_valid_o(address_valid_o));
`default_nettype wire

// File: tb/link_host_model.sv
`default_nettype none
module link_host_model (
  // Serial link pins
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock idles low between frames
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // MSB first from bits[39]; n below the full count aborts the frame
  task automatic frame(input logic [39:0] bits, input int n);
    int i;
    #3 cs_n_o = 1'b0;
    #24;
    for (i = 0; i < n; i++) begin
      si_o = bits[39-i];
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    // Released line shows the inverse so a stale value cannot pass
    si_o = ~si_o;
    #64;
  endtask
endmodule
`default_nettype wire

// File: tb/test_flash_status_bank_protect_regs.sv
`default_nettype none
module test_flash_status_bank_protect_regs;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, full_address_o, rd;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic erase_suspend_i = 1'b0, erase_resume_i = 1'b0, program_suspend_i = 1'b0, program_resume_i = 1'b0;
  logic ack_o, erase_suspended_o, program_suspended_o, wide_address_enable_o;
  logic key_mode_active_o, persistent_mode_active_o, address_valid_o;
  wire sck_i, cs_n_i, si_i;
  int failures = 0, checked = 0, valid_count = 0, n0;

  flash_status_bank_protect_regs flash_status_bank_protect_regs_i (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .erase_suspend_i(erase_suspend_i), .erase_resume_i(erase_resume_i),
    .program_suspend_i(program_suspend_i), .program_resume_i(program_resume_i), .sck_i(sck_i),
    .cs_n_i(cs_n_i), .si_i(si_i), .erase_suspended_o(erase_suspended_o),
    .program_suspended_o(program_suspended_o), .wide_address_enable_o(wide_address_enable_o),
    .key_mode_active_o(key_mode_active_o), .persistent_mode_active_o(persistent_mode_active_o),
    .full_address_o(full_address_o), .address_valid_o(address_valid_o));
  link_host_model link_host_model_i (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));

  always #4 clk_i = ~clk_i;
  // Count capture pulses so a missing or doubled one shows
  always @(posedge clk_i) if (address_valid_o === 1'b1) valid_count <= valid_count + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ack and read data are taken at the rising edge; the request drops right after it
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    adr_i <= a; we_i <= w; dat_i <= d; sel_i <= s; cyc_i <= 1'b1; stb_i <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 40);
    rd = dat_o;
    if (n >= 40) failures++;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask
  task rd_cmp(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0, 4'h0);
    cmp32(rd, exp);
  endtask
  // Mask order: erase suspend, erase resume, program suspend, program resume
  task ev(input logic [3:0] m);
    @(posedge clk_i) {erase_suspend_i, erase_resume_i, program_suspend_i, program_resume_i} <= m;
    @(posedge clk_i) {erase_suspend_i, erase_resume_i, program_suspend_i, program_resume_i} <= 4'h0;
    @(negedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task test_reset;
    rd_cmp(flash_regs_pkg::OFS_STATUS_TWO, 32'h0);
    rd_cmp(flash_regs_pkg::OFS_BANK_ADDRESS_SELECT, 32'h0);
    rd_cmp(flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG, 32'h0000_fe7f);
    rd_cmp(flash_regs_pkg::OFS_KEY_LOW, 32'hffff_ffff);
    rd_cmp(flash_regs_pkg::OFS_KEY_HIGH, 32'hffff_ffff);
    rd_cmp(8'h20, 32'h0);
    cmp1(wide_address_enable_o, 1'b0);
  endtask
  task test_suspend;
    ev(4'h8);
    rd_cmp(flash_regs_pkg::OFS_STATUS_TWO, 32'h2);
    wb(flash_regs_pkg::OFS_STATUS_TWO, 1'b1, 32'h0000_00ff, 4'hf);
    rd_cmp(flash_regs_pkg::OFS_STATUS_TWO, 32'h2);
    ev(4'h2);
    cmp1(program_suspended_o, 1'b1);
    rd_cmp(flash_regs_pkg::OFS_STATUS_TWO, 32'h3);
    ev(4'h4);
    rd_cmp(flash_regs_pkg::OFS_STATUS_TWO, 32'h1);
    ev(4'h1);
    cmp1(program_suspended_o, 1'b0);
    rd_cmp(flash_regs_pkg::OFS_STATUS_TWO, 32'h0);
    ev(4'hc);
    cmp1(erase_suspended_o, 1'b1);
    ev(4'h4);
  endtask
  task test_bank;
    wb(flash_regs_pkg::OFS_BANK_ADDRESS_SELECT, 1'b1, 32'h0000_00ff, 4'hf);
    rd_cmp(flash_regs_pkg::OFS_BANK_ADDRESS_SELECT, 32'h83);
    cmp1(wide_address_enable_o, 1'b1);
    wb(flash_regs_pkg::OFS_BANK_ADDRESS_SELECT, 1'b1, 32'h0000_0001, 4'h1);
    rd_cmp(flash_regs_pkg::OFS_BANK_ADDRESS_SELECT, 32'h01);
    cmp1(wide_address_enable_o, 1'b0);
  endtask
  // Key bits only go from one to zero, lane by lane
  task test_key;
    wb(flash_regs_pkg::OFS_KEY_LOW, 1'b1, 32'h1234_5678, 4'hf);
    rd_cmp(flash_regs_pkg::OFS_KEY_LOW, 32'h1234_5678);
    wb(flash_regs_pkg::OFS_KEY_HIGH, 1'b1, 32'h0000_abcd, 4'h3);
    rd_cmp(flash_regs_pkg::OFS_KEY_HIGH, 32'hffff_abcd);
    wb(flash_regs_pkg::OFS_KEY_LOW, 1'b1, 32'hffff_ffff, 4'hf);
    rd_cmp(flash_regs_pkg::OFS_KEY_LOW, 32'h1234_5678);
  endtask
  task test_guard;
    wb(flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG, 1'b1, 32'hffff_fffb, 4'hf);
    rd_cmp(flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG, 32'h0000_fe7b);
    cmp1(key_mode_active_o, 1'b1);
    rd_cmp(flash_regs_pkg::OFS_KEY_LOW, 32'hffff_ffff);
    rd_cmp(flash_regs_pkg::OFS_KEY_HIGH, 32'hffff_ffff);
    wb(flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG, 1'b1, 32'hffff_ffff, 4'hf);
    rd_cmp(flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG, 32'h0000_fe7b);
    wb(flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG, 1'b1, 32'h0000_00fd, 4'h1);
    rd_cmp(flash_regs_pkg::OFS_SECTOR_GUARD_CONFIG, 32'h0000_fe79);
    cmp1(persistent_mode_active_o, 1'b1);
  endtask
  // Bank bit 0 is set from the bank scenario, so narrow frames land above 16 MB
  task test_link;
    n0 = valid_count;
    link_host_model_i.frame({8'h03, 24'ha5_c33c, 8'h00}, 32);
    cmp1(valid_count == n0 + 1, 1'b1);
    cmp32(full_address_o, 32'h01a5_c33c);
    rd_cmp(flash_regs_pkg::OFS_LINK_ADDRESS, 32'h01a5_c33c);
    link_host_model_i.frame({8'h03, 32'h0}, 20);
    cmp1(valid_count == n0 + 1, 1'b1);
    wb(flash_regs_pkg::OFS_BANK_ADDRESS_SELECT, 1'b1, 32'h0000_0080, 4'h1);
    link_host_model_i.frame({8'h0b, 32'hdead_beef}, 40);
    cmp1(valid_count == n0 + 2, 1'b1);
    cmp32(full_address_o, 32'hdead_beef);
  endtask

  task finish_test;
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_suspend();
    test_bank();
    test_key();
    test_guard();
    test_link();
    finish_test();
  end
  // Watchdog, far beyond the fewer than a thousand cycles the run needs
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
